// File: inc/rcal_consts.vh
`ifndef RCAL_CONSTS_VH
`define RCAL_CONSTS_VH
// Register offsets
`define RCAL_A_RSVD 4'h0
`define RCAL_A_SEC 4'h1
`define RCAL_A_MIN 4'h2
`define RCAL_A_HOUR 4'h3
`define RCAL_A_WDAY 4'h4
`define RCAL_A_DATE 4'h5
`define RCAL_A_CMON 4'h6
`define RCAL_A_YEAR 4'h7
`define RCAL_A_TRIM 4'h8
`define RCAL_A_WDOG 4'h9
`define RCAL_A_AMON 4'hA
`define RCAL_A_ADATE 4'hB
`define RCAL_A_AHOUR 4'hC
`define RCAL_A_AMIN 4'hD
`define RCAL_A_ASEC 4'hE
`define RCAL_A_FLAGS 4'hF
// Field positions
`define RCAL_B_TOP 7
`define RCAL_B_SUB 6
`define RCAL_B_BATT 5
`define RCAL_B_CAL_SIGN 5
// Repeat codes, order b5 b4 b3 b2 b1 b6
`define RCAL_RPT_WEEK 6'h3F
`define RCAL_RPT_SEC 6'h3E
`define RCAL_RPT_MIN 6'h3C
`define RCAL_RPT_HOUR 6'h38
`define RCAL_RPT_DAY 6'h30
`define RCAL_RPT_MONTH 6'h20
`define RCAL_RPT_YEAR 6'h00
// Reset value of every register byte
`define RCAL_RST_BYTE 8'h00
// Crystal ticks per second
`define RCAL_XTAL_HZ 32768
`endif

// File: verilog/rcal_core.v
`timescale 1ns/1ps
`default_nettype none
`include "rcal_consts.vh"
// Function
// R01: Time, date and alarm kept in BCD; sec/min 00-59, hours 00-23, date 01-31.
// R02: Calibration (sign D5) and watchdog fields stored as plain binary.
// R03: Format bit D7 at 08h: 0 is 24-hour, 1 is 12-hour.
// R04: In 12-hour mode during PM, light dot of the last display digit.
// R05: Seconds register D7 is the oscillator stop control.
// R06: Watchdog register: multiplier D6..D2, resolution on D7 and D1..D0.
// R07: Last alarm register: D7 watchdog flag enable, D6..D4 alarm weekday.
// R08: Alarm month, date, hour, minute, second matches sit at 0Ah to 0Eh.
// R09: Six repeat bits live in the top bits of alarm registers.
// R10: Repeat code selects weekly, second, minute, hourly, daily, monthly, yearly matching.
// R11: Unlisted repeat code makes the alarm fire every second.
// R12: After reset the repeat mode is yearly.
// R13: On match set alarm flag; interrupt only when alarm flag enable set.
// R14: Pending alarm interrupt clears only on host read of interrupt registers.
// R15: Alarm keeps firing in standby and acts as a wake source.
// R16: Alarm month D5 enables the alarm while on battery backup.
// R17: Two-bit century counts up when year rolls from 99 to 00.
// R18: Years divisible by 4 leap; year 00 leap only with century 00.
// R19: Date rolls over after 28, 29, 30 or 31 by month and leap year.
// R20: Power-on: oscillator stop, alarm enable, watchdog enable and controls zero.
// R21: Host writes zero to unused bits after cold boot.
// R22: Host never programs an invalid date.
// R23: Display select in hours register picks HM, MS, date-month or month-date.
// R24: Register address increments after each byte written or read.
// R25: Each BCD field carries into the next field when passing its maximum.
module rcal_core #(
  parameter TICKS_PER_SEC = `RCAL_XTAL_HZ
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_xtal_tick,
  input wire i_addr_load,
  input wire [3:0] i_addr,
  input wire i_wr_stb,
  input wire [7:0] i_wr_data,
  input wire i_rd_stb,
  input wire i_irq_read,
  input wire i_standby,
  input wire i_on_battery,
  output reg [7:0] o_rd_data,
  output reg [3:0] o_addr,
  output wire o_alarm_flag,
  output wire o_alarm_irq,
  output wire o_wake,
  output reg [7:0] o_disp_hi,
  output reg [7:0] o_disp_lo,
  output wire o_pm_dot,
  output wire o_osc_halted,
  output wire o_twelve_hour,
  output wire [7:0] o_wd_setting,
  output wire [5:0] o_cal_trim
);

  reg [7:0] regs_q [0:15];
  reg [1:0] tick_sync_q;
  reg tick_prev_q;
  reg [15:0] div_q;
  reg flag_q;
  wire tick_rise;
  wire sec_pulse;
  integer k;

  // Crystal tick crosses into the system clock through two flops first
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      tick_sync_q <= 2'h0;
      tick_prev_q <= 1'b0;
    end else begin
      tick_sync_q <= {tick_sync_q[0], i_xtal_tick};
      tick_prev_q <= tick_sync_q[1];
    end
  end
  assign tick_rise = tick_sync_q[1] & ~tick_prev_q;

  // Shorthand views of the register bytes
  wire [7:0] sec = regs_q[`RCAL_A_SEC];
  wire [7:0] mnt = regs_q[`RCAL_A_MIN];
  wire [7:0] hr = regs_q[`RCAL_A_HOUR];
  wire [7:0] wd = regs_q[`RCAL_A_WDAY];
  wire [7:0] dt = regs_q[`RCAL_A_DATE];
  wire [7:0] cm = regs_q[`RCAL_A_CMON];
  wire [7:0] yr = regs_q[`RCAL_A_YEAR];
  wire [7:0] amon = regs_q[`RCAL_A_AMON];
  wire [7:0] adate = regs_q[`RCAL_A_ADATE];
  wire [7:0] ahour = regs_q[`RCAL_A_AHOUR];
  wire [7:0] amin = regs_q[`RCAL_A_AMIN];
  wire [7:0] asec = regs_q[`RCAL_A_ASEC];
  wire [7:0] aflg = regs_q[`RCAL_A_FLAGS];

  assign o_osc_halted = sec[`RCAL_B_TOP]; // R05
  assign o_twelve_hour = regs_q[`RCAL_A_TRIM][`RCAL_B_TOP]; // R03
  assign o_wd_setting = regs_q[`RCAL_A_WDOG]; // R06
  assign o_cal_trim = regs_q[`RCAL_A_TRIM][5:0]; // R02

  // Seconds divider; a halted oscillator freezes the count
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      div_q <= 16'h0000;
    end else if (tick_rise && !o_osc_halted) begin
      if (div_q == TICKS_PER_SEC - 1) begin
        div_q <= 16'h0000;
      end else begin
        div_q <= div_q + 16'h0001;
      end
    end
  end
  assign sec_pulse = tick_rise && !o_osc_halted && (div_q == TICKS_PER_SEC - 1);

  // BCD increment; a ones digit of 9 wraps to 0 and carries into tens, field tops are wrapped by the caller
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9) begin
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
    end
  endfunction

  // Calendar limits
  wire sec_wrap = sec[6:0] == 7'h59; // R01
  wire min_wrap = mnt[6:0] == 7'h59; // R01
  wire hr_wrap = hr[5:0] == 6'h23; // R01
  wire [4:0] month = cm[4:0];
  wire year_bin_div4 = ((yr[7:4] & 4'h1) == 4'h0) ? (yr[1:0] == 2'h0) : (yr[1:0] == 2'h2);
  // Year 00 is leap only in the first century code
  wire leap = year_bin_div4 && ((yr != 8'h00) || (cm[7:6] == 2'h0)); // R18
  reg [7:0] last_day;
  always @* begin
    case (month)
      5'h02: last_day = leap ? 8'h29 : 8'h28; // R19
      5'h04, 5'h06, 5'h09, 5'h11: last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  end
  wire day_wrap = dt[5:0] == last_day[5:0]; // R19
  wire mon_wrap = month == 5'h12;
  wire yr_wrap = yr == 8'h99;

  // Incremented fields; only the field's own bits are used so control bits above survive
  wire [7:0] sec_inc = bcd_inc({1'b0, sec[6:0]});
  wire [7:0] min_inc = bcd_inc({1'b0, mnt[6:0]});
  wire [7:0] hr_inc = bcd_inc({2'h0, hr[5:0]});
  wire [7:0] dt_inc = bcd_inc({2'h0, dt[5:0]});
  wire [7:0] mon_inc = bcd_inc({3'h0, month});

  // Alarm matching; repeat code ordered b5 b4 b3 b2 b1 b6
  wire [5:0] rpt = {adate[`RCAL_B_SUB], adate[`RCAL_B_TOP], ahour[`RCAL_B_TOP],
    amin[`RCAL_B_TOP], asec[`RCAL_B_TOP], ahour[`RCAL_B_SUB]}; // R09
  wire m_sec = sec[6:0] == asec[6:0];
  wire m_min = mnt[6:0] == amin[6:0];
  wire m_hr = hr[5:0] == ahour[5:0];
  wire m_dt = dt[5:0] == adate[5:0];
  wire m_mon = month == amon[4:0];
  wire m_wd = wd[2:0] == aflg[6:4]; // R07
  reg match;
  always @* begin
    case (rpt) // R10
      `RCAL_RPT_WEEK: match = m_wd & m_hr & m_min & m_sec;
      `RCAL_RPT_SEC: match = 1'b1;
      `RCAL_RPT_MIN: match = m_sec;
      `RCAL_RPT_HOUR: match = m_min & m_sec;
      `RCAL_RPT_DAY: match = m_hr & m_min & m_sec;
      `RCAL_RPT_MONTH: match = m_dt & m_hr & m_min & m_sec;
      `RCAL_RPT_YEAR: match = m_mon & m_dt & m_hr & m_min & m_sec;
      default: match = 1'b1; // R11
    endcase
  end
  // Battery operation needs its own enable; standby alone does not block it
  wire alarm_allowed = !i_on_battery || amon[`RCAL_B_BATT]; // R16 R15
  wire alarm_event = sec_pulse && match && alarm_allowed; // R13

  // Flag: set wins over a simultaneous interrupt-register read
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      flag_q <= 1'b0;
    end else if (alarm_event) begin
      flag_q <= 1'b1; // R13
    end else if (i_irq_read) begin
      flag_q <= 1'b0; // R14
    end
  end
  assign o_alarm_flag = flag_q;
  assign o_alarm_irq = flag_q && amon[`RCAL_B_TOP]; // R13
  assign o_wake = o_alarm_irq && i_standby; // R15

  // Address pointer steps after every data byte
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_addr <= 4'h0;
    end else if (i_addr_load) begin
      o_addr <= i_addr;
    end else if (i_wr_stb || i_rd_stb) begin
      o_addr <= o_addr + 4'h1; // R24
    end
  end

  // Read data is registered on the read strobe
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rd_data <= `RCAL_RST_BYTE;
    end else if (i_rd_stb) begin
      o_rd_data <= (o_addr == `RCAL_A_RSVD) ? 8'h00 : regs_q[o_addr];
    end
  end

  // Register file and time keeping; a host write takes priority over a tick
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      for (k = 0; k < 16; k = k + 1) begin
        regs_q[k] <= `RCAL_RST_BYTE; // R20 R12
      end
    end else begin
      if (sec_pulse) begin
        regs_q[`RCAL_A_SEC] <= {sec[7], sec_wrap ? 7'h00 : sec_inc[6:0]}; // R25
        if (sec_wrap) begin
          regs_q[`RCAL_A_MIN] <= {mnt[7], min_wrap ? 7'h00 : min_inc[6:0]};
          if (min_wrap) begin
            regs_q[`RCAL_A_HOUR] <= {hr[7:6], hr_wrap ? 6'h00 : hr_inc[5:0]};
            if (hr_wrap) begin
              regs_q[`RCAL_A_WDAY] <= {wd[7:3], wd[2:0] == 3'h7 ? 3'h1 : wd[2:0] + 3'h1};
              regs_q[`RCAL_A_DATE] <= {dt[7:6], day_wrap ? 6'h01 : dt_inc[5:0]};
              if (day_wrap) begin
                if (mon_wrap) begin
                  regs_q[`RCAL_A_YEAR] <= yr_wrap ? 8'h00 : bcd_inc(yr);
                  regs_q[`RCAL_A_CMON] <= {yr_wrap ? cm[7:6] + 2'h1 : cm[7:6], cm[5], 5'h01}; // R17
                end else begin
                  regs_q[`RCAL_A_CMON] <= {cm[7:5], mon_inc[4:0]}; // R17
                end
              end
            end
          end
        end
      end
      if (i_wr_stb && o_addr != `RCAL_A_RSVD) begin
        regs_q[o_addr] <= i_wr_data; // R08
      end
    end
  end

  // Display mapping; 12-hour view converts the 24-hour count
  wire pm = hr[5:0] >= 6'h12;
  reg [7:0] h12;
  always @* begin
    if (hr[5:0] == 6'h00 || hr[5:0] == 6'h12) begin
      h12 = 8'h12;
    end else if (pm) begin
      h12 = (hr[3:0] >= 4'h2) ? {2'h0, hr[5:4] - 2'h1, hr[3:0] - 4'h2}
        : {2'h0, hr[5:4] - 2'h2, hr[3:0] + 4'h8};
    end else begin
      h12 = {2'h0, hr[5:0]};
    end
  end
  // Display pairs are registered; they trail a register change by one cycle
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_disp_hi <= 8'h00;
      o_disp_lo <= 8'h00;
    end else begin
      case (hr[7:6]) // R23
        2'h1: begin
          o_disp_hi <= {1'b0, mnt[6:0]};
          o_disp_lo <= {1'b0, sec[6:0]};
        end
        2'h2: begin
          o_disp_hi <= {2'h0, dt[5:0]};
          o_disp_lo <= {3'h0, month};
        end
        2'h3: begin
          o_disp_hi <= {3'h0, month};
          o_disp_lo <= {2'h0, dt[5:0]};
        end
        default: begin
          o_disp_hi <= o_twelve_hour ? h12 : {2'h0, hr[5:0]}; // R03
          o_disp_lo <= {1'b0, mnt[6:0]};
        end
      endcase
    end
  end
  assign o_pm_dot = o_twelve_hour && pm; // R04

endmodule // rcal_core
`default_nettype wire

// File: test/rcal_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host on the register port; lines it lets go carry junk, never the old value
module rcal_host (
  input wire logic i_sys_clk,
  input wire logic [7:0] i_q,
  output logic o_ld,
  output logic [3:0] o_a,
  output logic o_wr,
  output logic [7:0] o_d,
  output logic o_rd,
  output logic o_ir
);
  initial {o_ld, o_a, o_wr, o_d, o_rd, o_ir} = 16'h0000;
  // One edge per strobe; the next request waits for a fresh edge
  task automatic ld(input logic [3:0] a);
    @(posedge i_sys_clk);
    o_ld <= 1'h1;
    o_a <= a;
    @(posedge i_sys_clk);
    o_ld <= 1'h0;
    o_a <= ~a;
  endtask
  // Callers keep spare bits at zero and dates valid
  task automatic wr(input logic [7:0] d);
    @(posedge i_sys_clk);
    o_wr <= 1'h1;
    o_d <= d;
    @(posedge i_sys_clk);
    o_wr <= 1'h0;
    o_d <= ~d;
  endtask
  task automatic rd(output logic [7:0] q);
    @(posedge i_sys_clk);
    o_rd <= 1'h1;
    @(posedge i_sys_clk);
    o_rd <= 1'h0;
    #1 q = i_q;
  endtask
  // Status read that releases a pending alarm
  task automatic clr;
    @(posedge i_sys_clk);
    o_ir <= 1'h1;
    @(posedge i_sys_clk);
    o_ir <= 1'h0;
  endtask
endmodule // rcal_host
`default_nettype wire

// File: test/rcal_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level watch on the calendar core
module rcal_chk (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_addr_load,
  input wire logic [3:0] i_addr,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  input wire logic i_irq_read,
  input wire logic i_standby,
  input wire logic [7:0] o_rd_data,
  input wire logic [3:0] o_addr,
  input wire logic o_alarm_flag,
  input wire logic o_alarm_irq,
  input wire logic o_wake,
  input wire logic o_pm_dot,
  input wire logic o_twelve_hour,
  input wire logic [7:0] o_wd_setting
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Byte strobe that moves the pointer on by one
  sequence s_step;
    (i_wr_stb || i_rd_stb) && !i_addr_load;
  endsequence
  sequence s_idle;
    !i_addr_load && !i_wr_stb && !i_rd_stb;
  endsequence
  chk_ptr_load: assert property (i_addr_load |=> o_addr == $past(i_addr))
    else $error("pointer load missed");
  chk_ptr_step: assert property (s_step |=> o_addr == $past(o_addr) + 4'h1)
    else $error("pointer did not step");
  chk_ptr_hold: assert property (s_idle |=> $stable(o_addr))
    else $error("pointer moved while idle");
  chk_rd_hold: assert property (!i_rd_stb |=> $stable(o_rd_data))
    else $error("read data moved");
  chk_irq_gate: assert property (o_alarm_irq |-> o_alarm_flag)
    else $error("interrupt without flag");
  chk_wake_path: assert property (o_wake == (o_alarm_irq && i_standby))
    else $error("wake mismatch");
  chk_flag_sticky: assert property (o_alarm_flag && !i_irq_read |=> o_alarm_flag)
    else $error("flag dropped unread");
  chk_flag_clear: assert property ($fell(o_alarm_flag) && !$past(i_rst) |-> $past(i_irq_read))
    else $error("flag cleared without read");
  chk_pm_mode: assert property (o_pm_dot |-> o_twelve_hour)
    else $error("pm dot in 24 hour mode");
  chk_wd_hold: assert property (!i_wr_stb |=> $stable(o_wd_setting))
    else $error("watchdog field moved");
endmodule // rcal_chk
bind rcal_core rcal_chk u_rcal_chk (.*);
`default_nettype wire

// File: test/rcal_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rcal_core_tb;
  logic i_sys_clk, i_rst, i_xtal_tick, i_addr_load, i_wr_stb, i_rd_stb;
  logic i_irq_read, i_standby, i_on_battery, o_alarm_flag, o_alarm_irq, o_wake;
  logic o_pm_dot, o_osc_halted, o_twelve_hour;
  logic [3:0] i_addr, o_addr;
  logic [7:0] i_wr_data, o_rd_data, o_disp_hi, o_disp_lo, o_wd_setting;
  logic [5:0] o_cal_trim;
  int fail_count, comparisons, cycles;
  // Four ticks a second keeps calendar runs short
  rcal_core #(.TICKS_PER_SEC(4)) u_rcal_core (.*);
  rcal_host u_rcal_host (.i_sys_clk, .i_q(o_rd_data), .o_ld(i_addr_load), .o_a(i_addr),
    .o_wr(i_wr_stb), .o_d(i_wr_data), .o_rd(i_rd_stb), .o_ir(i_irq_read));
  initial begin
    i_sys_clk = 1'h0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, far above the roughly 800 cycles the run needs
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Whole seconds of crystal edges, then room for sync and flag update
  task automatic sec(input int n);
    repeat (n * 4) begin
      repeat (4) @(posedge i_sys_clk);
      i_xtal_tick <= 1'h1;
      repeat (4) @(posedge i_sys_clk);
      i_xtal_tick <= 1'h0;
    end
    repeat (6) @(posedge i_sys_clk);
  endtask
  task automatic w1(input logic [3:0] a, input logic [7:0] d);
    u_rcal_host.ld(a);
    u_rcal_host.wr(d);
  endtask
  // Burst writes and reads lean on the pointer stepping
  task automatic ws(input logic [3:0] a, input logic [7:0] v[7], input int n);
    u_rcal_host.ld(a);
    for (int k = 0; k < n; k++)
      u_rcal_host.wr(v[k]);
  endtask
  task automatic rs(input logic [3:0] a, input logic [7:0] v[7], input int n);
    logic [7:0] q;
    u_rcal_host.ld(a);
    for (int k = 0; k < n; k++) begin
      u_rcal_host.rd(q);
      chk(q, v[k]);
    end
  endtask
  task automatic t_reset;
    logic [7:0] q;
    u_rcal_host.ld(4'h0);
    repeat (16) begin
      u_rcal_host.rd(q);
      chk(q, 8'h00);
    end
    chk({4'h0, o_addr}, 8'h00);
  endtask
  // From 23:59:59 one second rolls every field up to the given date
  task automatic t_cal(input logic [7:0] d, m, y, ed, em, ey);
    ws(4'h1, '{8'h59, 8'h59, 8'h23, 8'h07, d, m, y}, 7);
    sec(1);
    rs(4'h1, '{8'h00, 8'h00, 8'h00, 8'h01, ed, em, ey}, 7);
  endtask
  task automatic t_halt;
    w1(4'h1, 8'h92);
    sec(1);
    rs(4'h1, '{8'h92, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
    chk({7'h00, o_osc_halted}, 8'h01);
    w1(4'h1, 8'h12);
    sec(1);
    rs(4'h1, '{8'h13, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
  endtask
  task automatic t_alarm;
    ws(4'h1, '{8'h30, 8'h20, 8'h10, 8'h03, 8'h15, 8'h06, 8'h23}, 7);
    ws(4'hA, '{8'h86, 8'h15, 8'h10, 8'h20, 8'h31, 8'h00, 8'h00}, 5);
    sec(1);
    chk({7'h00, o_alarm_flag}, 8'h00);
    sec(1);
    chk({6'h00, o_alarm_flag, o_alarm_irq}, 8'h03);
    i_standby <= 1'h1;
    @(posedge i_sys_clk);
    #1 chk({7'h00, o_wake}, 8'h01);
    u_rcal_host.clr();
    #1 chk({7'h00, o_alarm_flag}, 8'h00);
    @(posedge i_sys_clk);
    i_on_battery <= 1'h1;
    ws(4'hA, '{8'h06, 8'h15, 8'h50, 8'h20, 8'h31, 8'h00, 8'h00}, 5);
    sec(1);
    chk({7'h00, o_alarm_flag}, 8'h00);
    w1(4'hA, 8'h26);
    sec(1);
    chk({6'h00, o_alarm_flag, o_alarm_irq}, 8'h02);
  endtask
  // Display pairs are registered, so each display check waits one edge after the write
  task automatic t_disp;
    ws(4'h1, '{8'h07, 8'h45, 8'h53, 8'h00, 8'h00, 8'h00, 8'h00}, 3);
    w1(4'h8, 8'h80);
    @(posedge i_sys_clk);
    #1 chk(o_disp_hi, 8'h45);
    chk(o_disp_lo, 8'h07);
    chk({6'h00, o_pm_dot, o_twelve_hour}, 8'h03);
    w1(4'h3, 8'h13);
    @(posedge i_sys_clk);
    #1 chk(o_disp_hi, 8'h01);
    chk(o_disp_lo, 8'h45);
    w1(4'h3, 8'h93);
    @(posedge i_sys_clk);
    #1 chk(o_disp_hi, 8'h15);
    chk(o_disp_lo, 8'h06);
    w1(4'h3, 8'hD3);
    @(posedge i_sys_clk);
    #1 chk(o_disp_hi, 8'h06);
    chk(o_disp_lo, 8'h15);
    w1(4'h9, 8'hA5);
    #1 chk(o_wd_setting, 8'hA5);
    w1(4'h8, 8'h25);
    #1 chk({2'h0, o_cal_trim}, 8'h25);
  endtask
  // Reset for two edges, then each scenario in turn
  initial begin
    i_rst = 1'h1;
    i_xtal_tick = 1'h0;
    i_standby = 1'h0;
    i_on_battery = 1'h0;
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'h0;
    t_reset();
    t_cal(8'h28, 8'h02, 8'h23, 8'h01, 8'h03, 8'h23);
    t_cal(8'h28, 8'h02, 8'h24, 8'h29, 8'h02, 8'h24);
    t_cal(8'h28, 8'h02, 8'h00, 8'h29, 8'h02, 8'h00);
    t_cal(8'h28, 8'h42, 8'h00, 8'h01, 8'h43, 8'h00);
    t_cal(8'h30, 8'h04, 8'h23, 8'h01, 8'h05, 8'h23);
    t_cal(8'h31, 8'h12, 8'h99, 8'h01, 8'h41, 8'h00);
    t_halt();
    t_alarm();
    t_disp();
    wrap_up();
  end
endmodule // rcal_core_tb
`default_nettype wire
